// ### logic/iloe_pkg.sv
/*
 * Package for the indexed literal offset execute block: register map,
 * field positions, encodings, reset values and the phase sequence.
 * Assumes a single 100 MHz core clock and an AHB-Lite register bus.
 */
package iloe_pkg;
    // register byte offsets
    localparam logic [7:0] ILOE_CTRL_OFS = 8'h00;
    localparam logic [7:0] ILOE_INSTR_OFS = 8'h04;
    localparam logic [7:0] ILOE_FPTR_OFS = 8'h08;
    localparam logic [7:0] ILOE_ACCUM_OFS = 8'h0c;
    localparam logic [7:0] ILOE_STATUS_OFS = 8'h10;
    localparam logic [7:0] ILOE_ADDR_OFS = 8'h14;
    localparam logic [7:0] ILOE_MEM_OFS = 8'h18;
    // reset values
    localparam logic ILOE_XEN_RST = 1'b0;
    localparam logic [11:0] ILOE_FPTR_RST = 12'h000;
    localparam logic [7:0] ILOE_ACCUM_RST = 8'h00;
    localparam logic [4:0] ILOE_FLAGS_RST = 5'h00;
    // flag positions in the status register
    localparam int ILOE_FLAG_C = 0;
    localparam int ILOE_FLAG_DIGIT_CARRY = 1;
    localparam int ILOE_FLAG_Z = 2;
    localparam int ILOE_FLAG_OVERFLOW = 3;
    localparam int ILOE_FLAG_N = 4;
    localparam int ILOE_BUSY_BIT = 8;
    // operand limit and opcode patterns
    localparam logic [7:0] ILOE_OFS_MAX = 8'h5f;
    localparam logic [5:0] ILOE_OP_ADD = 6'b00_1001;
    localparam logic [3:0] ILOE_OP_BSET = 4'b1000;
    localparam logic [7:0] ILOE_OP_FILL = 8'b0110_1000;
    localparam logic [7:0] ILOE_FILL_VAL = 8'hff;
    localparam int ILOE_MEM_DEPTH = 4096;
    typedef enum logic [2:0] {
        ILOE_IDLE = 3'b000,
        ILOE_DECODE = 3'b001,
        ILOE_READ = 3'b010,
        ILOE_PROC = 3'b011,
        ILOE_WRITE = 3'b100
    } iloe_phase_e;
    typedef enum logic [1:0] {
        ILOE_K_NONE = 2'b00,
        ILOE_K_ADD = 2'b01,
        ILOE_K_BSET = 2'b10,
        ILOE_K_FILL = 2'b11
    } iloe_kind_e;
endpackage

// ### logic/iloe_exec.sv
/*
 * Indexed literal offset decode and execute, with a small data memory,
 * frame pointer, accumulator and status flags behind an AHB-Lite slave.
 * Assumes a single-master AHB-Lite bus on core_clk_i and a synchronous
 * reset; software writes an instruction word to start an execution.
 */
`timescale 1ns/1ps
module iloe_exec
    import iloe_pkg::*;
(
    // clock, reset, enable
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    // ahb-lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // status
    output logic busy_o,
    output logic not_indexed_o
);
    logic extended_set_enable;
    logic [11:0] frame_pointer_reg;
    logic [7:0] accum;
    logic [4:0] flags;
    logic [7:0] mem [ILOE_MEM_DEPTH];
    logic [15:0] instr;
    iloe_phase_e phase;
    iloe_kind_e kind;
    logic [11:0] eff_addr;
    logic [7:0] operand;
    logic [7:0] result;
    logic [4:0] next_flags;
    logic dest_mem;
    logic [11:0] mem_ptr;
    logic [8:0] add_sum;
    logic [4:0] add_low;
    // bus pipeline
    logic dp_valid;
    logic dp_write;
    logic [7:0] dp_addr;
    logic addr_phase;

    assign addr_phase = hsel_i && htrans_i[1] && hready_i && clk_en_i;

    // decoding used for both execute start and status visibility
    function automatic iloe_kind_e decode_kind(input logic [15:0] w,
                                               input logic xen);
        iloe_kind_e k;
        k = ILOE_K_NONE;
        // a bit zero and short operand only
        if (xen && !w[8] && w[7:0] <= ILOE_OFS_MAX) begin
            if (w[15:10] == ILOE_OP_ADD && !w[8]) begin
                k = ILOE_K_ADD;
            end else if (w[15:12] == ILOE_OP_BSET) begin
                k = ILOE_K_BSET;
            end else if (w[15:8] == ILOE_OP_FILL) begin
                k = ILOE_K_FILL;
            end
        end
        return k;
    endfunction

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            dp_valid <= 1'b0;
            dp_write <= 1'b0;
            dp_addr <= 8'h00;
        end else if (clk_en_i && hready_i) begin
            dp_valid <= addr_phase;
            dp_write <= hwrite_i;
            dp_addr <= haddr_i[7:0];
        end
    end

    // mem window pointer auto-increments on data access
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            mem_ptr <= 12'h000;
        end else if (clk_en_i && dp_valid) begin
            if (dp_write && dp_addr == ILOE_ADDR_OFS) begin
                mem_ptr <= hwdata_i[11:0];
            end else if (dp_addr == ILOE_MEM_OFS) begin
                mem_ptr <= mem_ptr + 12'h001;
            end
        end
    end

    // configuration bit, off after reset
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            extended_set_enable <= ILOE_XEN_RST;
        end else if (clk_en_i && dp_valid && dp_write
                     && dp_addr == ILOE_CTRL_OFS) begin
            extended_set_enable <= hwdata_i[0];
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            frame_pointer_reg <= ILOE_FPTR_RST;
        end else if (clk_en_i && dp_valid && dp_write
                     && dp_addr == ILOE_FPTR_OFS) begin
            frame_pointer_reg <= hwdata_i[11:0];
        end
    end

    // phase sequencer; bus writes of instr ignored while busy
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            phase <= ILOE_IDLE;
            instr <= 16'h0000;
            not_indexed_o <= 1'b0;
        end else if (clk_en_i) begin
            case (phase)
                ILOE_IDLE: begin
                    if (dp_valid && dp_write
                        && dp_addr == ILOE_INSTR_OFS) begin
                        instr <= hwdata_i[15:0];
                        phase <= ILOE_DECODE;
                    end
                end
                ILOE_DECODE: begin
                    not_indexed_o <= (decode_kind(instr, extended_set_enable)
                                      == ILOE_K_NONE);
                    phase <= (decode_kind(instr, extended_set_enable)
                              == ILOE_K_NONE) ? ILOE_IDLE : ILOE_READ;
                end
                ILOE_READ: phase <= ILOE_PROC;
                ILOE_PROC: phase <= ILOE_WRITE;
                ILOE_WRITE: phase <= ILOE_IDLE;
                default: phase <= ILOE_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            busy_o <= 1'b0;
        end else if (clk_en_i) begin
            busy_o <= (phase == ILOE_IDLE) ? (dp_valid && dp_write
                      && dp_addr == ILOE_INSTR_OFS)
                      : !(phase == ILOE_WRITE ||
                          (phase == ILOE_DECODE &&
                           decode_kind(instr, extended_set_enable)
                           == ILOE_K_NONE));
        end
    end

    // decode phase latches kind and indexed address
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            kind <= ILOE_K_NONE;
            eff_addr <= 12'h000;
            dest_mem <= 1'b0;
        end else if (clk_en_i && phase == ILOE_DECODE) begin
            kind <= decode_kind(instr, extended_set_enable);
            eff_addr <= frame_pointer_reg + {4'h0, instr[7:0]};
            dest_mem <= instr[9];
        end
    end

    // read phase fetches the indexed byte
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            operand <= 8'h00;
        end else if (clk_en_i && phase == ILOE_READ) begin
            operand <= mem[eff_addr];
        end
    end

    // process phase; adders kept outside the flop block
    assign add_sum = {1'b0, accum} + {1'b0, operand};
    assign add_low = {1'b0, accum[3:0]} + {1'b0, operand[3:0]};

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            result <= 8'h00;
            next_flags <= ILOE_FLAGS_RST;
        end else if (clk_en_i && phase == ILOE_PROC) begin
            next_flags <= flags;
            case (kind)
                ILOE_K_ADD: begin
                    result <= add_sum[7:0];
                    next_flags[ILOE_FLAG_C] <= add_sum[8];
                    next_flags[ILOE_FLAG_DIGIT_CARRY] <= add_low[4];
                    next_flags[ILOE_FLAG_Z] <= (add_sum[7:0] == 8'h00);
                    next_flags[ILOE_FLAG_N] <= add_sum[7];
                    next_flags[ILOE_FLAG_OVERFLOW] <= (accum[7] == operand[7])
                        && (add_sum[7] != accum[7]);
                end
                ILOE_K_BSET: result <= operand | (8'h01 << instr[11:9]);
                ILOE_K_FILL: result <= ILOE_FILL_VAL;
                default: result <= operand;
            endcase
        end
    end

    // write phase: accumulator, flags, memory
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            accum <= ILOE_ACCUM_RST;
            flags <= ILOE_FLAGS_RST;
        end else if (clk_en_i) begin
            if (phase == ILOE_WRITE && kind == ILOE_K_ADD) begin
                flags <= next_flags;
                if (!dest_mem) begin
                    accum <= result;
                end
            end else if (dp_valid && dp_write
                         && dp_addr == ILOE_ACCUM_OFS) begin
                accum <= hwdata_i[7:0];
            end
        end
    end

    // memory has no reset; contents are software data
    always_ff @(posedge core_clk_i) begin
        if (clk_en_i) begin
            if (phase == ILOE_WRITE && (kind != ILOE_K_ADD || dest_mem)) begin
                mem[eff_addr] <= result;
            end else if (dp_valid && dp_write && dp_addr == ILOE_MEM_OFS) begin
                mem[mem_ptr] <= hwdata_i[7:0];
            end
        end
    end

    // read mux, registered one cycle after address phase
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            hrdata_o <= 32'h0000_0000;
        end else if (clk_en_i && addr_phase && !hwrite_i) begin
            case (haddr_i[7:0])
                ILOE_CTRL_OFS: hrdata_o <= {31'h0, extended_set_enable};
                ILOE_INSTR_OFS: hrdata_o <= {16'h0000, instr};
                ILOE_FPTR_OFS: hrdata_o <= {20'h0_0000, frame_pointer_reg};
                ILOE_ACCUM_OFS: hrdata_o <= {24'h00_0000, accum};
                ILOE_STATUS_OFS: hrdata_o <= {22'h0, not_indexed_o,
                                              busy_o, 3'h0, flags};
                ILOE_ADDR_OFS: hrdata_o <= {20'h0_0000, mem_ptr};
                ILOE_MEM_OFS: hrdata_o <= {24'h00_0000, mem[mem_ptr]};
                default: hrdata_o <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end else begin
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end
    end

    add_dest_a: assert property (
        @(posedge core_clk_i) disable iff (sys_rst_i)
        clk_en_i && phase == ILOE_WRITE && kind == ILOE_K_ADD && !dest_mem
        |=> accum == $past(result))
        else $error("add result not in accumulator");
    fill_flags_a: assert property (
        @(posedge core_clk_i) disable iff (sys_rst_i)
        clk_en_i && phase == ILOE_WRITE && kind != ILOE_K_ADD
        |=> flags == $past(flags))
        else $error("flags changed by set instruction");
    fill_value_a: assert property (
        @(posedge core_clk_i) disable iff (sys_rst_i)
        clk_en_i && phase == ILOE_PROC && kind == ILOE_K_FILL
        |=> result == ILOE_FILL_VAL)
        else $error("fill value wrong");
    phase_walk_a: assert property (
        @(posedge core_clk_i) disable iff (sys_rst_i)
        clk_en_i && phase == ILOE_READ ##1 clk_en_i ##1 clk_en_i
        |-> phase == ILOE_WRITE)
        else $error("phase order broken");
    disabled_skip_a: assert property (
        @(posedge core_clk_i) disable iff (sys_rst_i)
        clk_en_i && phase == ILOE_DECODE && !extended_set_enable
        |=> phase == ILOE_IDLE)
        else $error("indexed run while extension off");
    range_a: assert property (
        @(posedge core_clk_i) disable iff (sys_rst_i)
        clk_en_i && phase == ILOE_DECODE && instr[7:0] > ILOE_OFS_MAX
        |=> phase == ILOE_IDLE)
        else $error("long operand treated as offset");
    index_addr_a: assert property (
        @(posedge core_clk_i) disable iff (sys_rst_i)
        clk_en_i && phase == ILOE_DECODE
        |=> eff_addr == 12'($past(frame_pointer_reg)
                            + {4'h0, $past(instr[7:0])}))
        else $error("indexed address wrong");
    // zero flag from the operands as they stood, not the updated accumulator
    zero_flag_a: assert property (
        @(posedge core_clk_i) disable iff (sys_rst_i)
        clk_en_i && phase == ILOE_WRITE && kind == ILOE_K_ADD
        |=> flags[ILOE_FLAG_Z]
            == (8'($past(accum) + $past(operand)) == 8'h00))
        else $error("zero flag wrong");
    freeze_hold_a: assert property (
        @(posedge core_clk_i) disable iff (sys_rst_i)
        !clk_en_i |=> phase == $past(phase) && busy_o == $past(busy_o))
        else $error("state moved while clock enable low");
endmodule

// ### test/testbench.sv
/*
 * Self-checking bench for the indexed literal offset execute block.
 * Assumes iloe_pkg and iloe_exec are compiled first; the bench is the
 * only AHB-Lite master and drives every input port itself except hready_i,
 * which is looped back from hreadyout_o.
 */
`timescale 1ns/1ps
module testbench
    import iloe_pkg::*;
;
    logic core_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic hsel_i = 1'b0;
    logic [31:0] haddr_i = 32'h0000_0000;
    logic [1:0] htrans_i = 2'h0;
    logic hwrite_i = 1'b0;
    logic [2:0] hsize_i = 3'h2;
    logic [31:0] hwdata_i = 32'h0000_0000;
    logic [31:0] hrdata_o;
    logic hreadyout_o;
    logic hresp_o;
    logic busy_o;
    logic not_indexed_o;
    int n_fail = 0;
    int n_checks = 0;
    logic clk_en_i = 1'b1;

    always #5 core_clk_i = ~core_clk_i;

    iloe_exec dut (
        .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
        .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
        .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
        .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
        .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .busy_o(busy_o),
        .not_indexed_o(not_indexed_o)
    );

    task automatic chk(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one single word transfer; waits on hready in both phases
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        @(posedge core_clk_i);
        hsel_i <= 1'b1;
        htrans_i <= 2'h2;
        haddr_i <= {24'h00_0000, a};
        hwrite_i <= w;
        do @(posedge core_clk_i); while (hreadyout_o !== 1'b1);
        htrans_i <= 2'h0;
        hsel_i <= 1'b0;
        hwdata_i <= wd;
        do @(posedge core_clk_i); while (hreadyout_o !== 1'b1);
        rd = hrdata_o;
        chk("hresp", {31'h0, hresp_o}, 32'h0);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask

    task automatic rd(input string name, input logic [7:0] a,
                      input logic [31:0] exp);
        logic [31:0] r;
        bus(1'b0, a, 32'h0000_0000, r);
        chk(name, r, exp);
    endtask

    task automatic mset(input logic [11:0] ad, input logic [7:0] d);
        wr(ILOE_ADDR_OFS, {20'h0_0000, ad});
        wr(ILOE_MEM_OFS, {24'h00_0000, d});
    endtask

    task automatic mchk(input logic [11:0] ad, input logic [7:0] d);
        wr(ILOE_ADDR_OFS, {20'h0_0000, ad});
        rd("mem", ILOE_MEM_OFS, {24'h00_0000, d});
    endtask

    // start an instruction and count the cycles busy stays up
    task automatic exec(input logic [15:0] ins, input logic idx);
        int cnt;
        cnt = 0;
        wr(ILOE_INSTR_OFS, {16'h0000, ins});
        // busy rises at the write edge itself, so look before waiting
        for (int i = 0; i < 20; i++) begin
            #1;
            if (busy_o === 1'b1) cnt++;
            else break;
            @(posedge core_clk_i);
        end
        chk("busy cycles", cnt, idx ? 4 : 1);
        chk("not_indexed", {31'h0, not_indexed_o}, {31'h0, !idx});
    endtask

    task automatic s_reset();
        chk("hreadyout", {31'h0, hreadyout_o}, 32'h0000_0001);
        rd("ctrl", ILOE_CTRL_OFS, 32'h0000_0000);
        rd("fptr", ILOE_FPTR_OFS, 32'h0000_0000);
        rd("status", ILOE_STATUS_OFS, 32'h0000_0000);
        rd("accum", ILOE_ACCUM_OFS, 32'h0000_0000);
        rd("unmapped", 8'h40, 32'h0000_0000);
    endtask

    task automatic s_disabled();
        wr(ILOE_FPTR_OFS, 32'h0000_0a00);
        mset(12'ha2c, 8'h20);
        wr(ILOE_ACCUM_OFS, 32'h0000_0017);
        exec(16'h242c, 1'b0);
        rd("accum", ILOE_ACCUM_OFS, 32'h0000_0017);
        rd("status", ILOE_STATUS_OFS, 32'h0000_0200);
    endtask

    task automatic s_add();
        wr(ILOE_CTRL_OFS, 32'h0000_0001);
        exec(16'h242c, 1'b1);
        rd("accum", ILOE_ACCUM_OFS, 32'h0000_0037);
        mchk(12'ha2c, 8'h20);
        rd("status", ILOE_STATUS_OFS, 32'h0000_0000);
        // upper boundary offset, result to memory, carry out to zero
        mset(12'ha5f, 8'h80);
        wr(ILOE_ACCUM_OFS, 32'h0000_0080);
        exec(16'h265f, 1'b1);
        mchk(12'ha5f, 8'h00);
        rd("accum", ILOE_ACCUM_OFS, 32'h0000_0080);
        rd("status", ILOE_STATUS_OFS, 32'h0000_000d);
        // offset zero, signed overflow with half carry
        mset(12'ha00, 8'h01);
        wr(ILOE_ACCUM_OFS, 32'h0000_007f);
        exec(16'h2400, 1'b1);
        rd("accum", ILOE_ACCUM_OFS, 32'h0000_0080);
        rd("status", ILOE_STATUS_OFS, 32'h0000_001a);
    endtask

    task automatic s_refused();
        mset(12'ha60, 8'h11);
        exec(16'h2660, 1'b0);
        mchk(12'ha60, 8'h11);
        exec(16'h272c, 1'b0);
        mchk(12'ha2c, 8'h20);
        rd("status", ILOE_STATUS_OFS, 32'h0000_021a);
    endtask

    task automatic s_bset();
        for (int b = 0; b < 8; b++) begin
            mset(12'ha0a, 8'h00);
            exec({4'b1000, b[2:0], 1'b0, 8'h0a}, 1'b1);
            mchk(12'ha0a, 8'h01 << b);
        end
        mset(12'ha0a, 8'h55);
        exec(16'h8e0a, 1'b1);
        mchk(12'ha0a, 8'hd5);
        rd("status", ILOE_STATUS_OFS, 32'h0000_001a);
    endtask

    task automatic s_fill();
        mset(12'ha2c, 8'h00);
        mset(12'ha2d, 8'h3c);
        exec(16'h682c, 1'b1);
        mchk(12'ha2c, 8'hff);
        mchk(12'ha2d, 8'h3c);
        rd("status", ILOE_STATUS_OFS, 32'h0000_001a);
    endtask

    // enable dropped right after the start edge; run resumes once raised
    task automatic s_freeze();
        mset(12'ha30, 8'h00);
        wr(ILOE_INSTR_OFS, 32'h0000_6830);
        clk_en_i <= 1'b0;
        repeat (6) @(posedge core_clk_i);
        chk("busy frozen", {31'h0, busy_o}, 32'h0000_0001);
        clk_en_i <= 1'b1;
        repeat (5) @(posedge core_clk_i);
        #1;
        chk("busy done", {31'h0, busy_o}, 32'h0000_0000);
        mchk(12'ha30, 8'hff);
    endtask

    // reset between runs, with no run in progress, must switch the extension off again
    task automatic s_rst_mid();
        @(posedge core_clk_i);
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        rd("ctrl", ILOE_CTRL_OFS, 32'h0000_0000);
        exec(16'h682c, 1'b0);
        mchk(12'ha2c, 8'hff);
    endtask

    task automatic final_report();
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        s_reset();
        s_disabled();
        s_add();
        s_refused();
        s_bset();
        s_fill();
        s_freeze();
        s_rst_mid();
        final_report();
    end

    // whole run needs well under 2000 cycles
    initial begin
        repeat (20000) @(posedge core_clk_i);
        n_fail++;
        final_report();
    end
endmodule
